/* include/vfsr_pkg.sv */
package vfsr_pkg;

  // --------
  // register numbers on the serial register port
  // --------
  localparam logic [15:0] ADDR_STATUS     = 16'h0fa3;
  localparam logic [15:0] ADDR_ALGO       = 16'h1011;
  localparam logic [15:0] ADDR_SHORT_THR  = 16'h1012;
  localparam logic [15:0] ADDR_SHORT_HYS  = 16'h1013;
  localparam logic [15:0] ADDR_OPEN_TRAV  = 16'h1014;
  localparam logic [15:0] ADDR_CLOSE_TRAV = 16'h1015;
  localparam logic [15:0] ADDR_MIN_DRIVE  = 16'h1016;
  localparam logic [15:0] ADDR_SIG_FLOOR  = 16'h1017;
  localparam logic [15:0] ADDR_SIG_CEIL   = 16'h1018;
  localparam logic [15:0] ADDR_AUX_ERR    = 16'h1019;
  localparam logic [15:0] ADDR_FAULT_SEL  = 16'h101a;
  localparam logic [15:0] ADDR_AVG_CAP    = 16'h101b;
  localparam logic [15:0] ADDR_DEV_LIMIT  = 16'h101c;

  // --------
  // legal write ranges
  // --------
  localparam logic [15:0] ALGO_MAX      = 16'h0001;
  localparam logic [15:0] SHORT_MAX     = 16'h01f4;
  localparam logic [15:0] TRAVEL_MIN    = 16'h001e;
  localparam logic [15:0] TRAVEL_MAX    = 16'h1770;
  localparam logic [15:0] MIN_DRIVE_MIN = 16'h0001;
  localparam logic [15:0] MIN_DRIVE_MAX = 16'h03e7;
  localparam logic [15:0] SIG_MAX       = 16'h03e8;
  localparam logic [15:0] SEL_MAX       = 16'h0002;
  localparam logic [16:0] DEV_MAX       = 17'h1869f;

  // --------
  // reset values
  // --------
  localparam logic [15:0] RST_ALGO       = 16'h0000;
  localparam logic [15:0] RST_SHORT_THR  = 16'h01f4;
  localparam logic [15:0] RST_SHORT_HYS  = 16'h0000;
  localparam logic [15:0] RST_TRAVEL     = 16'h001e;
  localparam logic [15:0] RST_MIN_DRIVE  = 16'h0001;
  localparam logic [15:0] RST_SIG_FLOOR  = 16'h0000;
  localparam logic [15:0] RST_SIG_CEIL   = 16'h03e8;
  localparam logic [15:0] RST_SEL        = 16'h0000;
  localparam logic [15:0] RST_AVG_CAP    = 16'h03e8;
  localparam logic [16:0] RST_DEV_LIMIT  = 17'h00000;

  // --------
  // status word layout
  // --------
  localparam int ST_DP_MAIN    = 0;
  localparam int ST_DP_AUX     = 2;
  localparam int ST_TUNE_FAIL  = 4;
  localparam int ST_SOFT_START = 5;
  localparam int ST_TIMER_DONE = 6;
  localparam int ST_MANUAL     = 7;
  localparam int ST_TUNE_RUN   = 8;
  localparam int ST_GAIN_SET   = 9;
  localparam int ST_MAIN_RANGE = 13;
  localparam int ST_AUX_RANGE  = 14;
  localparam int ST_CTRL_ERR   = 15;
  localparam logic [1:0] DP_SENSOR = 2'h1;

  // --------
  // selections and output levels
  // --------
  localparam logic [1:0] AUXE_CLOSE   = 2'h0;
  localparam logic [1:0] AUXE_OPEN    = 2'h1;
  localparam logic [1:0] FAIL_OFF     = 2'h0;
  localparam logic [1:0] FAIL_PRESET  = 2'h1;
  localparam logic [1:0] FAIL_MEAN    = 2'h2;
  localparam logic [10:0] OUT_OFF     = 11'h000;
  localparam logic [10:0] OUT_HALF    = 11'h1f4;
  localparam logic [10:0] OUT_FULL    = 11'h3e8;

  // --------
  // timing
  // --------
  localparam longint unsigned CLK_HZ         = 64'd100000000;
  localparam longint unsigned MEAN_PERIOD_S  = 64'd60;
  localparam longint unsigned MEAN_PERIOD_CYC = MEAN_PERIOD_S * CLK_HZ;
  localparam int MEAN_SHIFT = 2;

endpackage

/* verilog/vfsr_mean_avg.sv */
`timescale 1ns/1ps
module vfsr_mean_avg
  import vfsr_pkg::*;
#(
  parameter int              W        = 11,
  parameter int              SHIFT    = MEAN_SHIFT,
  parameter longint unsigned INTERVAL = MEAN_PERIOD_CYC
) (
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  // sample side
  input  wire logic [W-1:0] sample_in,
  input  wire logic         allow_in,
  // result
  output logic      [W-1:0] mean_out,
  output logic              valid_out
);

  typedef enum logic [1:0] {
    AVG_EMPTY = 2'b01,
    AVG_RUN   = 2'b10
  } vfsr_avg_state_t;

  typedef struct packed {
    vfsr_avg_state_t   st;
    logic [63:0]       cnt;
    logic [W+SHIFT-1:0] acc;
    logic [W-1:0]      mean;
    logic              valid;
  } vfsr_avg_t;

  localparam vfsr_avg_t AVG_RST = '{st: AVG_EMPTY, cnt: '0, acc: '0,
                                    mean: '0, valid: 1'b0};

  vfsr_avg_t q;
  vfsr_avg_t next_q;
  logic [W+SHIFT:0] sum;

  always_comb begin
    next_q = q;
    sum = {1'b0, q.acc} - {{(SHIFT+1){1'b0}}, q.acc[W+SHIFT-1:SHIFT]}
          + {{(SHIFT+1){1'b0}}, sample_in};
    // one sample per interval, skipped while deviation is too large
    if (q.cnt >= INTERVAL - 64'd1) begin
      next_q.cnt = '0;
      if (allow_in) begin
        case (q.st)
          AVG_EMPTY: begin
            next_q.acc = {sample_in, {SHIFT{1'b0}}};
            next_q.st  = AVG_RUN;
          end
          AVG_RUN: begin
            next_q.acc = sum[W+SHIFT-1:0];
          end
          default: begin
            next_q.st = AVG_EMPTY;
          end
        endcase
      end
    end else begin
      next_q.cnt = q.cnt + 64'd1;
    end
    next_q.mean  = next_q.acc[W+SHIFT-1:SHIFT];
    next_q.valid = (next_q.st == AVG_RUN);
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      q <= AVG_RST;
    end else begin
      q <= next_q;
    end
  end

  assign mean_out  = q.mean;
  assign valid_out = q.valid;

endmodule

/* verilog/vfsr_regs.sv */
`timescale 1ns/1ps
// What this block does
// - one-bit setting picks valve algorithm: 0 no feedback, 1 feedback
// - holds short-circuit alarm threshold, writable 0..500 tenths ampere
// - short-circuit alarm applies writable hysteresis 0..500 tenths ampere
// - separate open and close travel times, each 30..6000 tenths second
// - minimum drive duration 1..999 tenths second; shorter steps not driven
// - control signal clamped between writable floor and ceiling, 0..1000
// - aux input error: 0 closes valve, 1 opens, 2 holds position
// - sensor fail or program stop: output off, preset, or averaged value
// - mean sampled once per minute, only while deviation under limit
// - averaged fail-safe output capped by writable limit 0..1000
// - holds maximum deviation for averaging, writable 0..65535 through the 16-bit port
// - on-off control: preset up to half gives 0, above gives full
// - status bits 0-1 main decimal point, bits 2-3 auxiliary one
// - status bit 4 tuning failed, bit 8 tuning running
// - status bit 5 soft start active, bit 6 timer countdown finished
// - status bit 7: 0 automatic, 1 manual
// - status bits 9-10 report active gain set, two-bit code
// - bits 13, 14 range errors main and auxiliary, bit 15 error
// - decimal point reads 1 for sensor inputs, else decimal places
module vfsr_regs
  import vfsr_pkg::*;
#(
  parameter int              SIG_W    = 11,
  parameter longint unsigned MEAN_CYC = MEAN_PERIOD_CYC
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  // register port
  input  wire logic [15:0]      reg_addr_in,
  input  wire logic [15:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [15:0]      reg_rdata_out,
  output logic                  reg_ack_out,
  output logic                  reg_err_out,
  // controller state for the status word
  input  wire logic             main_sensor_in,
  input  wire logic [1:0]       decimal_places_setting_in,
  input  wire logic             aux_sensor_in,
  input  wire logic [1:0]       aux_decimal_places_in,
  input  wire logic             tune_fail_in,
  input  wire logic             tune_run_in,
  input  wire logic             soft_start_in,
  input  wire logic             timer_done_in,
  input  wire logic             manual_mode_in,
  input  wire logic [1:0]       gain_set_in,
  input  wire logic             main_range_err_in,
  input  wire logic             aux_range_err_in,
  input  wire logic             ctrl_err_in,
  // control path
  input  wire logic [SIG_W-1:0] control_signal_in,
  input  wire logic [16:0]      deviation_in,
  input  wire logic             sensor_fail_in,
  input  wire logic             program_stop_in,
  input  wire logic             on_off_control_mode_in,
  input  wire logic [SIG_W-1:0] fault_preset_value_in,
  output logic      [SIG_W-1:0] drive_out,
  output logic                  failsafe_out,
  // actuator current
  input  wire logic [15:0]      actuator_current_in,
  output logic                  short_alarm_out,
  // stepper valve
  input  wire logic             aux_error_in,
  input  wire logic             open_req_in,
  input  wire logic             close_req_in,
  input  wire logic [15:0]      step_len_in,
  output logic                  valve_open_out,
  output logic                  valve_close_out,
  output logic                  valve_algorithm_select_out,
  output logic      [15:0]      valve_open_travel_out,
  output logic      [15:0]      valve_close_travel_out
);

  // --------
  // state
  // --------
  typedef struct packed {
    logic             algo;
    logic [15:0]      thr;
    logic [15:0]      hys;
    logic [15:0]      open_trav;
    logic [15:0]      close_trav;
    logic [15:0]      min_drive;
    logic [15:0]      floor_v;
    logic [15:0]      ceil_v;
    logic [1:0]       aux_sel;
    logic [1:0]       fault_sel;
    logic [15:0]      cap;
    logic [16:0]      dev_lim;
    logic [15:0]      status;
    logic [15:0]      rdata;
    logic             ack;
    logic             err;
    logic             alarm;
    logic [SIG_W-1:0] drive;
    logic             fs;
    logic             v_open;
    logic             v_close;
  } vfsr_state_t;

  localparam vfsr_state_t REG_RST = '{
    algo: RST_ALGO[0], thr: RST_SHORT_THR, hys: RST_SHORT_HYS,
    open_trav: RST_TRAVEL, close_trav: RST_TRAVEL,
    min_drive: RST_MIN_DRIVE, floor_v: RST_SIG_FLOOR,
    ceil_v: RST_SIG_CEIL, aux_sel: RST_SEL[1:0],
    fault_sel: RST_SEL[1:0], cap: RST_AVG_CAP, dev_lim: RST_DEV_LIMIT,
    status: '0, rdata: '0, ack: 1'b0, err: 1'b0, alarm: 1'b0,
    drive: '0, fs: 1'b0, v_open: 1'b0, v_close: 1'b0};

  vfsr_state_t q;
  vfsr_state_t next_q;

  logic [SIG_W-1:0] mean;
  logic             mean_valid;
  logic             mean_allow;

  // --------
  // helpers
  // --------
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [SIG_W-1:0] limit(input logic [SIG_W-1:0] v,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi);
    logic [15:0] t;
    t = {{(16-SIG_W){1'b0}}, v};
    if (t < lo) begin
      t = lo;
    end
    // ceiling wins when the two limits cross
    if (t > hi) begin
      t = hi;
    end
    limit = t[SIG_W-1:0];
  endfunction

  function automatic logic [1:0] dp_pos(input logic       sensor,
                                        input logic [1:0] places);
    dp_pos = sensor ? DP_SENSOR : places;
  endfunction

  // ----------------------------------------------------------------
  // running mean of the control signal
  // ----------------------------------------------------------------
  assign mean_allow = (deviation_in < q.dev_lim);

  vfsr_mean_avg #(
    .W        (SIG_W),
    .SHIFT    (MEAN_SHIFT),
    .INTERVAL (MEAN_CYC)
  ) u_mean (
    .clock_in  (clock_in),
    .rstn_in   (rstn_in),
    .sample_in (control_signal_in),
    .allow_in  (mean_allow),
    .mean_out  (mean),
    .valid_out (mean_valid)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic             ok;
    logic             hit;
    logic [15:0]      rd;
    logic [15:0]      release_lvl;
    logic [SIG_W-1:0] preset;
    logic [SIG_W-1:0] avg;
    next_q      = q;
    ok          = 1'b0;
    hit         = 1'b1;
    rd          = 16'h0000;
    release_lvl = 16'h0000;
    preset      = fault_preset_value_in;
    avg         = mean_valid ? mean : OUT_OFF[SIG_W-1:0];

    // status word, reserved bits stay zero
    next_q.status = 16'h0000;
    next_q.status[ST_DP_MAIN +: 2] =
      dp_pos(main_sensor_in, decimal_places_setting_in);
    next_q.status[ST_DP_AUX +: 2] =
      dp_pos(aux_sensor_in, aux_decimal_places_in);
    next_q.status[ST_TUNE_FAIL]  = tune_fail_in;
    next_q.status[ST_TUNE_RUN]   = tune_run_in;
    next_q.status[ST_SOFT_START] = soft_start_in;
    next_q.status[ST_TIMER_DONE] = timer_done_in;
    next_q.status[ST_MANUAL]     = manual_mode_in;
    next_q.status[ST_GAIN_SET +: 2] = gain_set_in;
    next_q.status[ST_MAIN_RANGE] = main_range_err_in;
    next_q.status[ST_AUX_RANGE]  = aux_range_err_in;
    next_q.status[ST_CTRL_ERR]   = ctrl_err_in;

    // ----------------------------------------------------------------
    // register port: write wins when both strobes come together
    // ----------------------------------------------------------------
    next_q.ack = reg_wr_in | reg_rd_in;
    next_q.err = 1'b0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_ALGO:       ok = in_range(reg_wdata_in, 16'h0000, ALGO_MAX);
        ADDR_SHORT_THR:  ok = in_range(reg_wdata_in, 16'h0000, SHORT_MAX);
        ADDR_SHORT_HYS:  ok = in_range(reg_wdata_in, 16'h0000, SHORT_MAX);
        ADDR_OPEN_TRAV:  ok = in_range(reg_wdata_in, TRAVEL_MIN, TRAVEL_MAX);
        ADDR_CLOSE_TRAV: ok = in_range(reg_wdata_in, TRAVEL_MIN, TRAVEL_MAX);
        ADDR_MIN_DRIVE:
          ok = in_range(reg_wdata_in, MIN_DRIVE_MIN, MIN_DRIVE_MAX);
        ADDR_SIG_FLOOR:  ok = in_range(reg_wdata_in, 16'h0000, SIG_MAX);
        ADDR_SIG_CEIL:   ok = in_range(reg_wdata_in, 16'h0000, SIG_MAX);
        ADDR_AUX_ERR:    ok = in_range(reg_wdata_in, 16'h0000, SEL_MAX);
        ADDR_FAULT_SEL:  ok = in_range(reg_wdata_in, 16'h0000, SEL_MAX);
        ADDR_AVG_CAP:    ok = in_range(reg_wdata_in, 16'h0000, SIG_MAX);
        ADDR_DEV_LIMIT:  ok = ({1'b0, reg_wdata_in} <= DEV_MAX);
        default:         ok = 1'b0;
      endcase
      // rejected writes leave the stored value alone
      if (ok) begin
        case (reg_addr_in)
          ADDR_ALGO:       next_q.algo       = reg_wdata_in[0];
          ADDR_SHORT_THR:  next_q.thr        = reg_wdata_in;
          ADDR_SHORT_HYS:  next_q.hys        = reg_wdata_in;
          ADDR_OPEN_TRAV:  next_q.open_trav  = reg_wdata_in;
          ADDR_CLOSE_TRAV: next_q.close_trav = reg_wdata_in;
          ADDR_MIN_DRIVE:  next_q.min_drive  = reg_wdata_in;
          ADDR_SIG_FLOOR:  next_q.floor_v    = reg_wdata_in;
          ADDR_SIG_CEIL:   next_q.ceil_v     = reg_wdata_in;
          ADDR_AUX_ERR:    next_q.aux_sel    = reg_wdata_in[1:0];
          ADDR_FAULT_SEL:  next_q.fault_sel  = reg_wdata_in[1:0];
          ADDR_AVG_CAP:    next_q.cap        = reg_wdata_in;
          ADDR_DEV_LIMIT:
            next_q.dev_lim = {1'b0, reg_wdata_in};
          default:         next_q.err        = 1'b1;
        endcase
      end else begin
        next_q.err = 1'b1;
      end
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_STATUS:     rd = q.status;
        ADDR_ALGO:       rd = {15'h0000, q.algo};
        ADDR_SHORT_THR:  rd = q.thr;
        ADDR_SHORT_HYS:  rd = q.hys;
        ADDR_OPEN_TRAV:  rd = q.open_trav;
        ADDR_CLOSE_TRAV: rd = q.close_trav;
        ADDR_MIN_DRIVE:  rd = q.min_drive;
        ADDR_SIG_FLOOR:  rd = q.floor_v;
        ADDR_SIG_CEIL:   rd = q.ceil_v;
        ADDR_AUX_ERR:    rd = {14'h0000, q.aux_sel};
        ADDR_FAULT_SEL:  rd = {14'h0000, q.fault_sel};
        ADDR_AVG_CAP:    rd = q.cap;
        // only the low 16 bits fit one register
        ADDR_DEV_LIMIT:  rd = q.dev_lim[15:0];
        default:         hit = 1'b0;
      endcase
      next_q.rdata = rd;
      next_q.err   = ~hit;
    end

    // ----------------------------------------------------------------
    // short-circuit alarm with hysteresis
    // ----------------------------------------------------------------
    release_lvl = (q.thr > q.hys) ? (q.thr - q.hys) : 16'h0000;
    if (!q.alarm && actuator_current_in >= q.thr) begin
      next_q.alarm = 1'b1;
    end else if (q.alarm && actuator_current_in < release_lvl) begin
      next_q.alarm = 1'b0;
    end

    // ----------------------------------------------------------------
    // control output and fail-safe policy
    // ----------------------------------------------------------------
    if (on_off_control_mode_in) begin
      preset = (fault_preset_value_in <= OUT_HALF[SIG_W-1:0]) ?
               OUT_OFF[SIG_W-1:0] : OUT_FULL[SIG_W-1:0];
    end
    if (avg > q.cap[SIG_W-1:0]) begin
      avg = q.cap[SIG_W-1:0];
    end
    next_q.fs = sensor_fail_in | program_stop_in;
    if (next_q.fs) begin
      case (q.fault_sel)
        FAIL_OFF:    next_q.drive = OUT_OFF[SIG_W-1:0];
        FAIL_PRESET: next_q.drive = preset;
        FAIL_MEAN:   next_q.drive = avg;
        default:     next_q.drive = OUT_OFF[SIG_W-1:0];
      endcase
    end else begin
      next_q.drive = limit(control_signal_in, q.floor_v, q.ceil_v);
    end

    // ----------------------------------------------------------------
    // stepper valve drive
    // ----------------------------------------------------------------
    if (aux_error_in) begin
      // hold position means neither coil is driven
      next_q.v_close = (q.aux_sel == AUXE_CLOSE);
      next_q.v_open  = (q.aux_sel == AUXE_OPEN);
    end else begin
      // too-short steps are dropped rather than stretched
      next_q.v_open  = open_req_in & ~close_req_in &
                       (step_len_in >= q.min_drive);
      next_q.v_close = close_req_in & ~open_req_in &
                       (step_len_in >= q.min_drive);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      q <= REG_RST;
    end else begin
      q <= next_q;
    end
  end

  // --------
  // outputs
  // --------
  assign reg_rdata_out              = q.rdata;
  assign reg_ack_out                = q.ack;
  assign reg_err_out                = q.err;
  assign drive_out                  = q.drive;
  assign failsafe_out               = q.fs;
  assign short_alarm_out            = q.alarm;
  assign valve_open_out             = q.v_open;
  assign valve_close_out            = q.v_close;
  assign valve_algorithm_select_out = q.algo;
  assign valve_open_travel_out      = q.open_trav;
  assign valve_close_travel_out     = q.close_trav;

endmodule

/* sim/vfsr_regs_props.sv */
`timescale 1ns/1ps
module vfsr_regs_props
  import vfsr_pkg::*;
(
  input wire logic        clock_in, rstn_in, reg_wr_in, reg_rd_in,
  input wire logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
  input wire logic        reg_err_out, main_sensor_in, tune_run_in,
  input wire logic        ctrl_err_in, sensor_fail_in, program_stop_in,
  input wire logic        failsafe_out, aux_error_in, valve_open_out,
  input wire logic        valve_close_out, valve_algorithm_select_out,
  input wire logic [15:0] step_len_in, valve_open_travel_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  wire st_rd   = reg_rd_in && !reg_wr_in && reg_addr_in == ADDR_STATUS;
  wire wr_algo = reg_wr_in && reg_addr_in == ADDR_ALGO;
  property p_algo;
    wr_algo && reg_wdata_in <= ALGO_MAX
      |=> valve_algorithm_select_out == $past(reg_wdata_in[0]);
  endproperty
  a_algo: assert property (p_algo) else $error("algo not stored");
  property p_algo_bad;
    wr_algo && reg_wdata_in > ALGO_MAX
      |=> reg_err_out && $stable(valve_algorithm_select_out);
  endproperty
  a_algo_bad: assert property (p_algo_bad) else $error("bad write kept");
  property p_travel;
    reg_wr_in && reg_addr_in == ADDR_OPEN_TRAV
      && reg_wdata_in inside {[TRAVEL_MIN:TRAVEL_MAX]}
      |=> valve_open_travel_out == $past(reg_wdata_in);
  endproperty
  a_travel: assert property (p_travel) else $error("travel lost");
  property p_ro;
    reg_wr_in && reg_addr_in == ADDR_STATUS |=> reg_err_out;
  endproperty
  a_ro: assert property (p_ro) else $error("status write accepted");
  property p_rsv;
    st_rd |=> reg_rdata_out[12:11] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_flags;
    st_rd && $stable({ctrl_err_in, tune_run_in}) |=>
      {reg_rdata_out[15], reg_rdata_out[8]}
        == $past({ctrl_err_in, tune_run_in});
  endproperty
  a_flags: assert property (p_flags) else $error("flag bits wrong");
  property p_dp;
    st_rd && main_sensor_in && $stable(main_sensor_in)
      |=> reg_rdata_out[1:0] == DP_SENSOR;
  endproperty
  a_dp: assert property (p_dp) else $error("sensor point wrong");
  property p_fs;
    ##1 failsafe_out == $past(sensor_fail_in | program_stop_in);
  endproperty
  a_fs: assert property (p_fs) else $error("failsafe flag wrong");
  property p_excl;
    !(valve_open_out && valve_close_out);
  endproperty
  a_excl: assert property (p_excl) else $error("valve both ways");
  property p_short;
    !aux_error_in && step_len_in == 16'h0
      |=> !valve_open_out && !valve_close_out;
  endproperty
  a_short: assert property (p_short) else $error("short step driven");
  c_st: cover property (st_rd);
  c_algo: cover property (wr_algo ##1 reg_err_out);
  c_fs: cover property (failsafe_out && valve_close_out);
endmodule
bind vfsr_regs vfsr_regs_props i_props (.*);

/* sim/vfsr_master.sv */
`timescale 1ns/1ps
module vfsr_master
  import vfsr_pkg::*;
(
  input  wire logic        clock_in,
  output logic      [15:0] reg_addr_in, reg_wdata_in,
  output logic             reg_wr_in, reg_rd_in,
  input  wire logic [15:0] reg_rdata_out,
  input  wire logic        reg_ack_out, reg_err_out
);
  logic [15:0] rdata;
  logic [1:0]  dp;
  logic        ack, err;
  initial begin
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
  end
  task automatic xfer(input logic w, input logic [15:0] a, d);
    @(negedge clock_in);
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {w, !w, a, d};
    @(negedge clock_in);
    {reg_wr_in, reg_rd_in} = 2'h0;
    {ack, err, rdata} = {reg_ack_out, reg_err_out, reg_rdata_out};
    if (!w && a == ADDR_STATUS) dp = rdata[1:0];
    // inverted idle values expose stale data
    {reg_addr_in, reg_wdata_in} = {~a, ~d};
  endtask
endmodule

/* sim/vfsr_regs_test.sv */
`timescale 1ns/1ps
module vfsr_regs_test;
  import vfsr_pkg::*;
  logic clock_in, rstn_in, reg_wr_in, reg_rd_in, reg_ack_out, reg_err_out;
  logic main_sensor_in, aux_sensor_in, tune_fail_in, tune_run_in;
  logic soft_start_in, timer_done_in, manual_mode_in, main_range_err_in;
  logic aux_range_err_in, ctrl_err_in, sensor_fail_in, program_stop_in;
  logic on_off_control_mode_in, aux_error_in, open_req_in, close_req_in;
  logic failsafe_out, short_alarm_out, valve_open_out, valve_close_out;
  logic valve_algorithm_select_out;
  logic [1:0]  decimal_places_setting_in, aux_decimal_places_in, gain_set_in;
  logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out, step_len_in;
  logic [15:0] actuator_current_in, valve_open_travel_out;
  logic [15:0] valve_close_travel_out;
  logic [16:0] deviation_in;
  logic [10:0] control_signal_in, fault_preset_value_in, drive_out;
  int fails, num_checks;
  logic [15:0] ad [12] = '{ADDR_ALGO, ADDR_SHORT_THR, ADDR_SHORT_HYS,
    ADDR_OPEN_TRAV, ADDR_CLOSE_TRAV, ADDR_MIN_DRIVE, ADDR_SIG_FLOOR,
    ADDR_SIG_CEIL, ADDR_AUX_ERR, ADDR_FAULT_SEL, ADDR_AVG_CAP, ADDR_DEV_LIMIT};
  logic [15:0] hi [12] = '{ALGO_MAX, SHORT_MAX, SHORT_MAX, TRAVEL_MAX,
    TRAVEL_MAX, MIN_DRIVE_MAX, SIG_MAX, SIG_MAX, SEL_MAX, SEL_MAX, SIG_MAX,
    16'hffff};
  logic [15:0] lo [12] = '{16'h0, 16'h0, 16'h0, TRAVEL_MIN, TRAVEL_MIN,
    MIN_DRIVE_MIN, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] rv [12] = '{RST_ALGO, RST_SHORT_THR, RST_SHORT_HYS, RST_TRAVEL,
    RST_TRAVEL, RST_MIN_DRIVE, RST_SIG_FLOOR, RST_SIG_CEIL, RST_SEL, RST_SEL,
    RST_AVG_CAP, RST_DEV_LIMIT[15:0]};

  vfsr_regs #(.MEAN_CYC(20)) i_dut (.*);
  vfsr_master i_m (.*);

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // --------
  // helpers
  // --------
  task automatic chk(input logic [17:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wn(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic wr(input logic [15:0] a, d, input logic e);
    i_m.xfer(1'b1, a, d);
    chk({i_m.ack, i_m.err}, {1'b1, e});
  endtask
  task automatic rd(input logic [15:0] a, exp, input logic e);
    i_m.xfer(1'b0, a, 16'h0);
    chk({i_m.ack, i_m.err, i_m.rdata}, {1'b1, e, exp});
  endtask
  task automatic t_out(input logic [10:0] c, e);
    control_signal_in = c;
    wn(2);
    chk(drive_out, e);
  endtask
  task automatic t_status(input logic [15:0] v, exp);
    {main_sensor_in, decimal_places_setting_in, aux_sensor_in,
     aux_decimal_places_in, tune_fail_in, soft_start_in, timer_done_in,
     manual_mode_in, tune_run_in, gain_set_in, main_range_err_in,
     aux_range_err_in, ctrl_err_in} = v;
    wn(2);
    rd(ADDR_STATUS, exp, 1'b0);
  endtask
  task automatic t_alarm(input logic [15:0] cur, input logic e);
    actuator_current_in = cur;
    wn(2);
    chk(short_alarm_out, e);
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_failsafe;
    wr(ADDR_FAULT_SEL, {14'h0, FAIL_MEAN}, 1'b0);
    wr(ADDR_DEV_LIMIT, 16'h64, 1'b0);
    {control_signal_in, deviation_in, sensor_fail_in} = {11'h320, 17'h64, 1'b1};
    wn(45); chk(drive_out, OUT_OFF);
    deviation_in = 17'h0;
    wn(45); chk(drive_out, 11'h320);
    wr(ADDR_AVG_CAP, 16'h12c, 1'b0);
    wn(2); chk(drive_out, 11'h12c);
    wr(ADDR_FAULT_SEL, {14'h0, FAIL_PRESET}, 1'b0);
    fault_preset_value_in = 11'h2bc;
    wn(2); chk(drive_out, 11'h2bc);
    {on_off_control_mode_in, fault_preset_value_in} = {1'b1, OUT_HALF};
    wn(2); chk(drive_out, OUT_OFF);
    fault_preset_value_in = OUT_HALF + 11'h1;
    wn(2); chk(drive_out, OUT_FULL);
    {sensor_fail_in, program_stop_in} = 2'b01;
    wr(ADDR_FAULT_SEL, {14'h0, FAIL_OFF}, 1'b0);
    wn(2); chk(drive_out, OUT_OFF);
    program_stop_in = 1'b0;
    wr(ADDR_SIG_FLOOR, 16'h64, 1'b0);
    wr(ADDR_SIG_CEIL, 16'h384, 1'b0);
    t_out(11'h32, 11'h64);
    t_out(11'h3b6, 11'h384);
    t_out(11'h1f4, 11'h1f4);
  endtask
  task automatic t_valve;
    wr(ADDR_MIN_DRIVE, 16'ha, 1'b0);
    aux_error_in = 1'b1;
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_AUX_ERR, 16'(s), 1'b0);
      wn(2);
      chk({valve_open_out, valve_close_out}, {s == 1, s == 0});
    end
    {aux_error_in, open_req_in, step_len_in} = {1'b0, 1'b1, 16'h9};
    wn(2); chk({valve_open_out, valve_close_out}, 2'b00);
    step_len_in = 16'ha;
    wn(2); chk({valve_open_out, valve_close_out}, 2'b10);
    {open_req_in, close_req_in} = 2'b01;
    wn(2); chk({valve_open_out, valve_close_out}, 2'b01);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end
  initial begin
    {rstn_in, main_sensor_in, aux_sensor_in, tune_fail_in, tune_run_in} = '0;
    {soft_start_in, timer_done_in, manual_mode_in, main_range_err_in} = '0;
    {aux_range_err_in, ctrl_err_in, sensor_fail_in, program_stop_in} = '0;
    {on_off_control_mode_in, aux_error_in, open_req_in, close_req_in} = '0;
    {decimal_places_setting_in, aux_decimal_places_in, gain_set_in} = '0;
    {step_len_in, actuator_current_in, deviation_in} = '0;
    {control_signal_in, fault_preset_value_in} = '0;
    repeat (12) @(posedge clock_in);
    @(negedge clock_in) rstn_in = 1'b1;
    for (int i = 0; i < 12; i++) rd(ad[i], rv[i], 1'b0);
    t_failsafe;
    for (int i = 0; i < 12; i++) begin
      wr(ad[i], hi[i], 1'b0);
      if (i < 11) wr(ad[i], hi[i] + 16'h1, 1'b1);
      rd(ad[i], hi[i], 1'b0);
      if (lo[i] != 16'h0) wr(ad[i], lo[i] - 16'h1, 1'b1);
      wr(ad[i], lo[i], 1'b0);
      rd(ad[i], lo[i], 1'b0);
    end
    rd(16'h1010, 16'h0, 1'b1);
    wr(ADDR_STATUS, 16'h0, 1'b1);
    t_status(16'heab2, 16'h4559);
    t_status(16'h514d, 16'ha2a6);
    wr(ADDR_SHORT_THR, 16'h64, 1'b0);
    wr(ADDR_SHORT_HYS, 16'h14, 1'b0);
    t_alarm(16'h64, 1'b1);
    t_alarm(16'h50, 1'b1);
    t_alarm(16'h4f, 1'b0);
    t_valve;
    tally_and_finish;
  end
endmodule
